/* File: hdl/rru_defs.svh */
// Purpose: Named constants for the reorder retirement unit
// Assumes: Single core clock, one design module
// Notes:   Sizes and rates are fixed, not parameters
`ifndef RRU_DEFS_SVH
`define RRU_DEFS_SVH

// ==========================================================
// Capacities
`define RRU_DEPTH      8'd126
`define RRU_LOAD_MAX   7'd48
`define RRU_STORE_MAX  6'd24

// ==========================================================
// Lane and entry counts (array bounds, used as plain integers)
`define RRU_RET_W      3
`define RRU_ALLOC_W    3
`define RRU_DONE_W     6
`define RRU_ENTRIES    126

// ==========================================================
// Field widths
`define RRU_SLOT_W     7
`define RRU_TAG_W      7
`define RRU_TGT_W      32
`define RRU_CODE_W     4
`define RRU_ARCH_W     3

`endif

/* File: hdl/rru_pkg.sv */
// Purpose: Types carried between the retirement unit and its neighbours
// Assumes: rru_defs.svh supplies every width except the occupancy counters
// Notes:   All carriers are packed structs
`include "rru_defs.svh"

package rru_pkg;

   // ==========================================================
   // One program order buffer entry
   typedef struct packed {
      logic                    busy;
      logic                    done;
      logic                    isBranch;
      logic                    mispred;
      logic                    fault;
      logic                    isLoad;
      logic                    isStore;
      logic                    writesReg;
      logic                    archFp;
      logic [`RRU_ARCH_W-1:0]  archIdx;
      logic [`RRU_TAG_W-1:0]   physTag;
      logic [`RRU_CODE_W-1:0]  faultCode;
      logic [`RRU_TGT_W-1:0]   target;
   } rru_entry_t;

   // ==========================================================
   // Requests and answers
   typedef struct packed {
      logic                    valid;
      logic                    isBranch;
      logic                    isLoad;
      logic                    isStore;
      logic                    writesReg;
      logic                    archFp;
      logic [`RRU_ARCH_W-1:0]  archIdx;
      logic [`RRU_TAG_W-1:0]   physTag;
   } rru_alloc_t;

   typedef struct packed {
      logic                    valid;
      logic [`RRU_SLOT_W-1:0]  slot;
      logic                    mispred;
      logic                    fault;
      logic [`RRU_CODE_W-1:0]  faultCode;
      logic [`RRU_TGT_W-1:0]   target;
   } rru_done_t;

   typedef struct packed {
      logic                    valid;
      logic                    archFp;
      logic [`RRU_ARCH_W-1:0]  archIdx;
      logic [`RRU_TAG_W-1:0]   physTag;
   } rru_commit_t;

   typedef struct packed {
      logic                    valid;
      logic                    mispred;
      logic [`RRU_TGT_W-1:0]   target;
   } rru_bupd_t;

   typedef struct packed {
      logic                    valid;
      logic [`RRU_CODE_W-1:0]  code;
      logic [`RRU_SLOT_W-1:0]  slot;
   } rru_exc_t;

   // ==========================================================
   // Whole state of the unit
   typedef struct packed {
      rru_entry_t [`RRU_ENTRIES-1:0]  ent;
      logic [`RRU_SLOT_W-1:0]         head;
      logic [`RRU_SLOT_W-1:0]         tail;
      logic [7:0]                     count;
      logic [6:0]                     loadCnt;
      logic [5:0]                     storeCnt;
      rru_commit_t [`RRU_RET_W-1:0]   commit;
      rru_bupd_t                      bupd;
      rru_exc_t                       exc;
      logic                           flush;
   } rru_state_t;

endpackage

/* File: hdl/rru_retire_unit.sv */
// Purpose: Program order buffer with in-order retirement
// Assumes: Allocation lanes are filled from lane 0 upward
// Notes:   Completion slots must name a busy entry below 126
// How it works
// - Results commit in issue order, whatever order they completed in.
// - At most three micro-ops retire in one cycle.
// - Entries wait until retirement; faults are reported oldest first.
// - Only done entries at the head retire; a done branch counts as resolved.
// - Commits name one of eight integer or eight float registers.
// - Each retired branch sends its target to the branch target table.
// - The buffer tracks up to 126 micro-ops in flight.
// - Up to 48 loads and 24 stores are tracked at once.
// - Work past an unresolved branch commits only after it, in order.
`include "rru_defs.svh"

module rru_retire_unit
   import rru_pkg::*;
(
   // Clock and reset
   input  wire logic                            clock,
   input  wire logic                            rst_n,
   // Allocation from the front end, in program order
   input  wire rru_alloc_t [`RRU_ALLOC_W-1:0]   allocIn,
   output      logic                            allocReady,
   output      logic [`RRU_ALLOC_W-1:0][`RRU_SLOT_W-1:0] allocSlot,
   // Completions from the execution core
   input  wire rru_done_t  [`RRU_DONE_W-1:0]    doneIn,
   // Architectural commit
   output      rru_commit_t [`RRU_RET_W-1:0]    commitOut,
   // Branch target table update
   output      rru_bupd_t                       branchUpd,
   // Exception and flush
   output      rru_exc_t                        excOut,
   output      logic                            flushOut
);

   rru_state_t s_q;
   rru_state_t s_d;

   // ==========================================================
   // Circular index arithmetic
   // Depth is not a power of two, so the index wraps by compare
   function automatic logic [`RRU_SLOT_W-1:0] wrapAdd(
      input logic [`RRU_SLOT_W-1:0] base,
      input logic [2:0]             inc);
      logic [7:0] sum;
      sum = {1'b0, base} + {5'h00, inc};
      if (sum >= `RRU_DEPTH) begin
         sum = sum - `RRU_DEPTH;
      end
      return sum[`RRU_SLOT_W-1:0];
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      logic [`RRU_SLOT_W-1:0] idx;
      logic                   stop;
      logic                   flushNow;
      logic [2:0]             nRet;
      logic [2:0]             nRetLd;
      logic [2:0]             nRetSt;
      logic [2:0]             nNew;
      logic [2:0]             nNewLd;
      logic [2:0]             nNewSt;
      logic                   fits;
      logic                   roomOk;
      logic                   loadOk;
      logic                   storeOk;
      rru_entry_t             e;
      idx      = s_q.head;
      stop     = 1'b0;
      flushNow = 1'b0;
      nRet     = 3'h0;
      nRetLd   = 3'h0;
      nRetSt   = 3'h0;
      nNew     = 3'h0;
      nNewLd   = 3'h0;
      nNewSt   = 3'h0;
      fits     = 1'b0;
      roomOk   = 1'b0;
      loadOk   = 1'b0;
      storeOk  = 1'b0;
      e        = '0;
      s_d        = s_q;
      s_d.commit = '0;
      s_d.bupd   = '0;
      s_d.exc    = '0;
      s_d.flush  = 1'b0;

      // ==========================================================
      // Completions land by slot in any order, six per cycle
      for (int j = 0; j < `RRU_DONE_W; j++) begin
         if (doneIn[j].valid && ({1'b0, doneIn[j].slot} < `RRU_DEPTH)
             && s_q.ent[doneIn[j].slot].busy) begin
            s_d.ent[doneIn[j].slot].done      = 1'b1;
            s_d.ent[doneIn[j].slot].mispred   = doneIn[j].mispred;
            s_d.ent[doneIn[j].slot].fault     = doneIn[j].fault;
            s_d.ent[doneIn[j].slot].faultCode = doneIn[j].faultCode;
            s_d.ent[doneIn[j].slot].target    = doneIn[j].target;
         end
      end

      // ==========================================================
      // Retirement walks from the head and stops at the first entry
      // that is not done, so nothing younger can overtake it
      for (int k = 0; k < `RRU_RET_W; k++) begin
         e = s_q.ent[idx];
         if (!stop && e.busy && e.done) begin
            if (e.fault) begin
               // Faulting op does not commit; it is the oldest left
               s_d.exc.valid = 1'b1;
               s_d.exc.code  = e.faultCode;
               s_d.exc.slot  = idx;
               flushNow      = 1'b1;
               stop          = 1'b1;
            end else begin
               s_d.commit[k].valid   = e.writesReg;
               s_d.commit[k].archFp  = e.archFp;
               s_d.commit[k].archIdx = e.archIdx;
               s_d.commit[k].physTag = e.physTag;
               s_d.ent[idx].busy     = 1'b0;
               nRet   = nRet + 3'h1;
               nRetLd = nRetLd + {2'b00, e.isLoad};
               nRetSt = nRetSt + {2'b00, e.isStore};
               if (e.isBranch) begin
                  // One table update per cycle keeps the port simple
                  s_d.bupd.valid   = 1'b1;
                  s_d.bupd.mispred = e.mispred;
                  s_d.bupd.target  = e.target;
                  flushNow         = e.mispred;
                  stop             = 1'b1;
               end
            end
            idx = wrapAdd(idx, 3'h1);
         end else begin
            stop = 1'b1;
         end
      end
      s_d.head = idx;

      // ==========================================================
      // Allocation is all or nothing; it uses occupancy before
      // this cycle's retirement, so it resumes one cycle later
      for (int i = 0; i < `RRU_ALLOC_W; i++) begin
         allocSlot[i] = wrapAdd(s_q.tail, nNew);
         if (allocIn[i].valid) begin
            nNew   = nNew + 3'h1;
            nNewLd = nNewLd + {2'b00, allocIn[i].isLoad};
            nNewSt = nNewSt + {2'b00, allocIn[i].isStore};
         end
      end
      roomOk  = (s_q.count + {5'h00, nNew}) <= `RRU_DEPTH;
      loadOk  = (s_q.loadCnt + {4'h0, nNewLd}) <= `RRU_LOAD_MAX;
      storeOk = (s_q.storeCnt + {3'h0, nNewSt}) <= `RRU_STORE_MAX;
      fits    = roomOk && loadOk && storeOk;
      allocReady = fits && !flushNow;

      if (allocReady) begin
         for (int i = 0; i < `RRU_ALLOC_W; i++) begin
            if (allocIn[i].valid) begin
               s_d.ent[allocSlot[i]]           = '0;
               s_d.ent[allocSlot[i]].busy      = 1'b1;
               s_d.ent[allocSlot[i]].isBranch  = allocIn[i].isBranch;
               s_d.ent[allocSlot[i]].isLoad    = allocIn[i].isLoad;
               s_d.ent[allocSlot[i]].isStore   = allocIn[i].isStore;
               s_d.ent[allocSlot[i]].writesReg = allocIn[i].writesReg;
               s_d.ent[allocSlot[i]].archFp    = allocIn[i].archFp;
               s_d.ent[allocSlot[i]].archIdx   = allocIn[i].archIdx;
               s_d.ent[allocSlot[i]].physTag   = allocIn[i].physTag;
            end
         end
         s_d.tail = wrapAdd(s_q.tail, nNew);
      end else begin
         nNew   = 3'h0;
         nNewLd = 3'h0;
         nNewSt = 3'h0;
      end

      // ==========================================================
      // Occupancy follows retirement and accepted allocation
      s_d.count    = s_q.count - {5'h00, nRet} + {5'h00, nNew};
      s_d.loadCnt  = s_q.loadCnt - {4'h0, nRetLd} + {4'h0, nNewLd};
      s_d.storeCnt = s_q.storeCnt - {3'h0, nRetSt} + {3'h0, nNewSt};

      // ==========================================================
      // Discard every younger entry and its rename result uncommitted
      if (flushNow) begin
         for (int n = 0; n < `RRU_ENTRIES; n++) begin
            s_d.ent[n].busy = 1'b0;
         end
         s_d.head     = '0;
         s_d.tail     = '0;
         s_d.count    = '0;
         s_d.loadCnt  = '0;
         s_d.storeCnt = '0;
         s_d.flush    = 1'b1;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Registered outputs
   assign commitOut = s_q.commit;
   assign branchUpd = s_q.bupd;
   assign excOut    = s_q.exc;
   assign flushOut  = s_q.flush;

endmodule // rru_retire_unit

/* File: verification/rru_retire_unit_asserts.sv */
// Purpose: Port-level checks on the retirement unit
// Assumes: Single clock domain, reset active low
// Notes:   Attached by bind below the module
module rru_retire_unit_asserts
   import rru_pkg::*;
(
   // Clock and reset
   input wire logic                 clock,
   input wire logic                 rst_n,
   // Allocation side
   input wire rru_alloc_t [2:0]     allocIn,
   input wire logic                 allocReady,
   input wire logic [2:0][6:0]      allocSlot,
   // Completion side
   input wire rru_done_t [5:0]      doneIn,
   // Results
   input wire rru_commit_t [2:0]    commitOut,
   input wire rru_bupd_t            branchUpd,
   input wire rru_exc_t             excOut,
   input wire logic                 flushOut
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // ==========
   // Slot wrap
   function automatic logic [6:0] nx(input logic [6:0] s);
      return (s == 7'd125) ? 7'd0 : 7'(s + 7'd1);
   endfunction

   // ==========
   // Properties
   chk_exc_flush: assert property (excOut.valid |-> flushOut)
      else $error("fault report without flush");
   chk_mis_flush: assert property (
      branchUpd.valid && branchUpd.mispred |-> flushOut)
      else $error("mispredict without flush");
   chk_flush_cause: assert property (flushOut |-> excOut.valid ||
      (branchUpd.valid && branchUpd.mispred))
      else $error("flush without cause");
   // Buffer is empty after a flush, so nothing can retire for two cycles
   chk_flush_quiet: assert property (flushOut |=>
      (!commitOut[0].valid && !branchUpd.valid && !excOut.valid)[*2])
      else $error("retirement right after flush");
   chk_flush_refuse: assert property (flushOut |-> !$past(allocReady))
      else $error("allocation taken while flushing");
   chk_flush_ready: assert property (flushOut |-> allocReady)
      else $error("allocation stalled on empty buffer");
   chk_slot_second: assert property (allocSlot[1] ==
      (allocIn[0].valid ? nx(allocSlot[0]) : allocSlot[0]))
      else $error("second lane slot wrong");
   chk_slot_third: assert property (allocSlot[2] ==
      (allocIn[1].valid ? nx(allocSlot[1]) : allocSlot[1]))
      else $error("third lane slot wrong");
   chk_slot_range: assert property (allocSlot[0] < 7'd126)
      else $error("slot beyond buffer");

   cover property (excOut.valid);
   cover property (branchUpd.valid && branchUpd.mispred);
   cover property (commitOut[2].valid);
   cover property (!allocReady);
endmodule // rru_retire_unit_asserts

bind rru_retire_unit rru_retire_unit_asserts rru_retire_unit_asserts_inst (
   .clock(clock), .rst_n(rst_n), .allocIn(allocIn),
   .allocReady(allocReady), .allocSlot(allocSlot), .doneIn(doneIn),
   .commitOut(commitOut), .branchUpd(branchUpd), .excOut(excOut),
   .flushOut(flushOut));

/* File: verification/rru_exec_model.sv */
// Purpose: Execution core and branch target table stand-in
// Assumes: Completions are launched on the falling edge
// Notes:   After each pulse all lanes carry inverted junk, never stale values; unused lanes in a pulse get slot s[i], code and target with valid low
module rru_exec_model
   import rru_pkg::*;
(
   // Clock
   input  wire logic       clock,
   // Completions toward the unit
   output rru_done_t [5:0] doneIn,
   // Branch target table update
   input  wire rru_bupd_t  branchUpd
);
   timeunit 1ns;
   timeprecision 1ns;
   int purged;
   initial begin
      doneIn = '0;
      purged = 0;
   end

   // ==========
   // Completion pulse; results live in rename tags only
   task automatic finish(input int n, input logic [6:0] s[6],
                         input logic mis, flt, input logic [3:0] code,
                         input logic [31:0] tgt);
      rru_done_t [5:0] t;
      @(negedge clock);
      for (int i = 0; i < 6; i++)
         doneIn[i] = '{i < n, s[i], i == 0 && mis, i == 0 && flt, code, tgt};
      @(negedge clock);
      t = ~doneIn;
      for (int i = 0; i < 6; i++) t[i].valid = 1'b0;
      doneIn = t;
   endtask

   // Redirecting update drops stale prefetched traces
   always @(posedge clock) begin
      if (branchUpd.valid === 1'b1 && branchUpd.mispred === 1'b1)
         purged <= purged + 1;
   end
endmodule // rru_exec_model

/* File: verification/rru_retire_unit_tb.sv */
// Purpose: Self-checking bench for the retirement unit
// Assumes: Inputs change on the falling clock edge
// Notes:   Each scenario ends with the buffer empty or flushed
module rru_retire_unit_tb
   import rru_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic               clock;
   logic               rst_n;
   rru_alloc_t  [2:0]  allocIn;
   logic               allocReady;
   logic [2:0][6:0]    allocSlot;
   rru_done_t   [5:0]  doneIn;
   rru_commit_t [2:0]  commitOut;
   rru_bupd_t          branchUpd;
   rru_exc_t           excOut;
   logic               flushOut;
   logic [6:0]         sl[6];
   int                 failCount;
   int                 nCompared;

   rru_retire_unit rru_retire_unit_inst (.clock(clock), .rst_n(rst_n),
      .allocIn(allocIn), .allocReady(allocReady), .allocSlot(allocSlot),
      .doneIn(doneIn), .commitOut(commitOut), .branchUpd(branchUpd),
      .excOut(excOut), .flushOut(flushOut));
   rru_exec_model rru_exec_model_inst (.clock(clock), .doneIn(doneIn),
      .branchUpd(branchUpd));

   // ==========
   // Helpers
   task automatic conclude();
      $display("compared %0d, mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      nCompared++;
      if (ok !== 1'b1) begin
         failCount++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic bounded(input int k);
      if (k >= 50) begin
         failCount++;
         $display("unexpected at %0t: wait ran out", $time);
         conclude();
      end
   endtask
   // Request is held until the edge that takes it
   task automatic alloc(input int n, off, input logic br, ld, st,
                        input logic [6:0] tag);
      int k;
      @(negedge clock);
      for (int i = 0; i < 3; i++)
         allocIn[i] = '{i < n, br, ld, st, 1'b1, i[0], 3'(tag + i),
                        7'(tag + i)};
      k = 0;
      #1;
      while (allocReady !== 1'b1 && k < 50) begin
         @(negedge clock);
         #1;
         k++;
      end
      bounded(k);
      for (int i = 0; i < n; i++) sl[off + i] = allocSlot[i];
      @(negedge clock);
      allocIn = '0;
   endtask
   task automatic waitOut();
      int k;
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while (commitOut[0].valid !== 1'b1 && excOut.valid !== 1'b1
                 && k < 50);
      bounded(k);
   endtask

   // ==========
   // Scenarios
   task automatic tOrder();
      logic [6:0] q[6];
      logic [6:0] e;
      rru_commit_t c;
      alloc(3, 0, 0, 0, 0, 7'h10);
      alloc(3, 3, 0, 0, 0, 7'h13);
      for (int i = 0; i < 6; i++) q[i] = sl[5 - i];
      rru_exec_model_inst.finish(6, q, 0, 0, 4'h0, 32'h0);
      waitOut();
      for (int g = 0; g < 2; g++) begin
         for (int i = 0; i < 3; i++) begin
            e = 7'(7'h10 + 3 * g + i);
            c = '{1'b1, i[0], e[2:0], e};
            chk(commitOut[i] === c, "commit order");
         end
         @(negedge clock);
      end
      $display("test order done");
   endtask
   task automatic tBranch();
      logic [6:0] q[6] = '{default: 7'h00};
      alloc(1, 0, 1, 0, 0, 7'h20);
      alloc(1, 1, 0, 0, 0, 7'h21);
      q[0] = sl[1];
      rru_exec_model_inst.finish(1, q, 0, 0, 4'h0, 32'h0);
      @(negedge clock);
      chk(commitOut[0].valid === 1'b0, "younger waits");
      q[0] = sl[0];
      rru_exec_model_inst.finish(1, q, 1, 0, 4'h0, 32'h0000_1234);
      waitOut();
      chk(branchUpd === '{1'b1, 1'b1, 32'h0000_1234}, "redirect");
      chk(commitOut[0].physTag === 7'h20, "branch commits");
      chk(flushOut === 1'b1, "redirect flush");
      chk(commitOut[1].valid === 1'b0, "younger discarded");
      alloc(1, 0, 1, 0, 0, 7'h22);
      q[0] = sl[0];
      rru_exec_model_inst.finish(1, q, 0, 0, 4'h0, 32'h0000_5678);
      waitOut();
      chk(branchUpd === '{1'b1, 1'b0, 32'h0000_5678}, "resolved");
      chk(flushOut === 1'b0, "no flush on good branch");
      chk(rru_exec_model_inst.purged == 1, "traces purged");
      $display("test branch done");
   endtask
   task automatic tFault();
      logic [6:0] q[6] = '{default: 7'h00};
      alloc(2, 0, 0, 0, 0, 7'h30);
      q[0] = sl[1];
      rru_exec_model_inst.finish(1, q, 0, 0, 4'h0, 32'h0);
      @(negedge clock);
      chk(commitOut[0].valid === 1'b0, "no overtaking");
      q[0] = sl[0];
      rru_exec_model_inst.finish(1, q, 0, 1, 4'h5, 32'h0);
      waitOut();
      chk(excOut === '{1'b1, 4'h5, sl[0]}, "fault report");
      chk(commitOut[0].valid === 1'b0, "fault not committed");
      chk(commitOut[1].valid === 1'b0 && flushOut === 1'b1, "flt");
      $display("test fault done");
   endtask
   // Fill one capacity, prove refusal, free the head, prove resumption
   task automatic tCap(input logic ld, st, input int k);
      logic [6:0] q[6] = '{default: 7'h00};
      for (int j = 0; j < k; j++) alloc(3, j > 0 ? 3 : 0, 0, ld, st, 7'h40);
      q[0] = sl[0];
      chk(q[0] === 7'h00, "restart slot");
      @(negedge clock);
      allocIn[0] = '{1'b1, 1'b0, ld, st, 1'b1, 1'b0, 3'h0, 7'h00};
      #1;
      chk(allocReady === 1'b0, "full refused");
      @(negedge clock);
      allocIn = '0;
      rru_exec_model_inst.finish(1, q, 0, 0, 4'h0, 32'h0);
      alloc(1, 0, 0, ld, st, 7'h50);
      chk(sl[0] === 7'((3 * k) % 126), "resume slot");
      q[0] = 7'h01;
      rru_exec_model_inst.finish(1, q, 0, 1, 4'h1, 32'h0);
      waitOut();
      chk(flushOut === 1'b1, "cleanup flush");
      $display("test capacity done");
   endtask

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      rst_n = 1'b0;
      allocIn = '0;
      failCount = 0;
      nCompared = 0;
      repeat (5) @(negedge clock);
      rst_n = 1'b1;
      tOrder();
      tBranch();
      tFault();
      tCap(1'b0, 1'b0, 42);
      tCap(1'b1, 1'b0, 16);
      tCap(1'b0, 1'b1, 8);
      conclude();
   end
endmodule // rru_retire_unit_tb
